// ===== estp_top.sv
// event stamp, second strobe and ascii time tag block
// assumes an AXI4-Lite master, a 50 MHz clock steered to satellite time,
// and two byte-wide serial transmitters with a ready handshake
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "estp_consts.svh"
module estp_top #(
    parameter int unsigned CYC_PER_SEC   = `ESTP_CYC_PER_SEC,
    parameter int unsigned TAG_START_CYC = `ESTP_TAG_START_CYC,
    parameter int unsigned LOG_DEPTH     = `ESTP_LOG_DEPTH
) (
    input  wire logic        CLOCK,
    input  wire logic        RST,
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    input  wire logic [1:0]  EVENT_IN,
    output logic             SECOND_STROBE_OUT,
    output logic [7:0]       TX_DATA,
    output logic             TX1_VALID,
    input  wire logic        TX1_READY,
    output logic             TX2_VALID,
    input  wire logic        TX2_READY,
    output logic             IRQ
);
    localparam int unsigned AW        = $clog2(LOG_DEPTH);
    localparam int unsigned PULSE_CYC = `ESTP_PULSE_CYC;
    localparam int unsigned LINE_W    = 8 * `ESTP_TAG_LEN;

    // refuse settings the counters cannot hold
    if (CYC_PER_SEC > 32'h04000000 || CYC_PER_SEC <= PULSE_CYC) begin : g_chk_sec
        $error("estp_top: CYC_PER_SEC out of range");
    end
    if (TAG_START_CYC >= CYC_PER_SEC) begin : g_chk_tag
        $error("estp_top: TAG_START_CYC must lie inside the second");
    end
    if (LOG_DEPTH < 2 || (1 << AW) != LOG_DEPTH) begin : g_chk_log
        $error("estp_top: LOG_DEPTH must be a power of two");
    end

    logic [4:0]  ctrl;
    logic [23:0] pps_ofs;
    logic [31:0] date;
    logic [11:0] soln;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_en;
    logic [4:0]  hour;
    logic [5:0]  minute;
    logic [5:0]  second;
    logic [25:0] cycle;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [31:0] w_mask;
    logic [3:0]  w_strb;
    logic        do_wr;
    logic [31:0] time_word;
    logic [31:0] rd_mux;
    logic        rd_known;
    logic        pop;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   log_cnt;
    logic [1:0]  hit;
    logic [1:0]  pend_v;
    logic [1:0]  grant;
    logic [42:0] stamp_v [2];
    logic        log_full;
    logic        push;
    logic        sec_wrap;
    logic [15:0] pulse_cnt;
    logic        pps_hit;
    logic [LINE_W-1:0] line;
    logic [LINE_W-1:0] next_line;
    logic [4:0]  sent;
    estp_pkg::estp_tag_state_t tag_state;
    logic        tag_port;
    logic        tx_take;
    logic        tag_done;

    estp_log_if #(.AW(AW)) log_bus ();

    estp_log_mem #(.DEPTH(LOG_DEPTH)) u_log (
        .clk (CLOCK),
        .log (log_bus)
    );

    // ---------------- AXI4-Lite slave ----------------
    // write address and data taken independently, response after both
    assign do_wr  = !AWREADY && !WREADY && !BVALID;
    assign w_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            AWREADY <= 1'b1;
            WREADY  <= 1'b1;
            BVALID  <= 1'b0;
            BRESP   <= `ESTP_RESP_OKAY;
            aw_addr <= 8'h00;
            w_data  <= 32'h00000000;
            w_strb  <= 4'h0;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_addr <= AWADDR;
                AWREADY <= 1'b0;
            end else if (BVALID && BREADY) begin
                AWREADY <= 1'b1;
            end
            if (WVALID && WREADY) begin
                w_data <= WDATA & {{8{WSTRB[3]}}, {8{WSTRB[2]}}, {8{WSTRB[1]}}, {8{WSTRB[0]}}};
                w_strb <= WSTRB;
                WREADY <= 1'b0;
            end else if (BVALID && BREADY) begin
                WREADY <= 1'b1;
            end
            if (do_wr) begin
                BVALID <= 1'b1;
                BRESP  <= (aw_addr == `ESTP_OFF_CTRL || aw_addr == `ESTP_OFF_PPS_OFS ||
                           aw_addr == `ESTP_OFF_TIME || aw_addr == `ESTP_OFF_DATE ||
                           aw_addr == `ESTP_OFF_SOLN || aw_addr == `ESTP_OFF_IRQ_CLR ||
                           aw_addr == `ESTP_OFF_IRQ_EN) ? `ESTP_RESP_OKAY : `ESTP_RESP_SLVERR;
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // configuration registers; unwritten byte lanes keep their value
    // capture enable bit
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ctrl    <= `ESTP_CTRL_RST;
            pps_ofs <= `ESTP_PPS_OFS_RST;
            date    <= `ESTP_DATE_RST;
            soln    <= `ESTP_SOLN_RST;
            irq_en  <= 4'h0;
        end else if (do_wr) begin
            case (aw_addr)
                `ESTP_OFF_CTRL:    ctrl    <= 5'((ctrl & ~w_mask[4:0]) | w_data[4:0]);
                `ESTP_OFF_PPS_OFS: pps_ofs <= (pps_ofs & ~w_mask[23:0]) | w_data[23:0];
                `ESTP_OFF_DATE:    date    <= (date & ~w_mask) | w_data;
                `ESTP_OFF_SOLN:    soln    <= (soln & ~w_mask[11:0]) | w_data[11:0];
                `ESTP_OFF_IRQ_EN:  irq_en  <= (irq_en & ~w_mask[3:0]) | w_data[3:0];
                default: ;
            endcase
        end
    end

    // read channel; a read of the low log word removes the oldest record
    assign time_word = {11'h000, hour, 2'h0, minute, 2'h0, second};
    always_comb begin
        rd_known = 1'b1;
        case (ARADDR)
            `ESTP_OFF_CTRL:     rd_mux = {27'h0, ctrl};
            `ESTP_OFF_PPS_OFS:  rd_mux = {8'h00, pps_ofs};
            `ESTP_OFF_TIME:     rd_mux = time_word;
            `ESTP_OFF_DATE:     rd_mux = date;
            `ESTP_OFF_SOLN:     rd_mux = {20'h00000, soln};
            `ESTP_OFF_LOG_CNT:  rd_mux = 32'(log_cnt);
            `ESTP_OFF_LOG_HI:   rd_mux = {log_bus.rd_data.port, 14'h0000, log_bus.rd_data.hour,
                                          log_bus.rd_data.minute, log_bus.rd_data.second};
            `ESTP_OFF_LOG_LO:   rd_mux = {6'h00, log_bus.rd_data.cycle};
            `ESTP_OFF_IRQ_STAT: rd_mux = {28'h0000000, irq_stat};
            `ESTP_OFF_IRQ_EN:   rd_mux = {28'h0000000, irq_en};
            `ESTP_OFF_IRQ_CLR:  rd_mux = 32'h00000000;
            default: begin
                rd_mux   = 32'h00000000;
                rd_known = 1'b0;
            end
        endcase
    end

    assign pop = ARVALID && ARREADY && ARADDR == `ESTP_OFF_LOG_LO && log_cnt != '0;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
            RDATA   <= 32'h00000000;
            RRESP   <= `ESTP_RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RDATA   <= rd_mux;
            RRESP   <= rd_known ? `ESTP_RESP_OKAY : `ESTP_RESP_SLVERR;
        end else if (RVALID && RREADY) begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
        end
    end

    // ---------------- time of day ----------------
    assign sec_wrap = cycle == 26'(CYC_PER_SEC - 1);

    // utc time, hours wrap at 24
    // free-running count keeps time without satellites
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cycle  <= 26'h0000000;
            second <= 6'h00;
            minute <= 6'h00;
            hour   <= 5'h00;
        end else if (do_wr && aw_addr == `ESTP_OFF_TIME) begin
            second <= 6'(((time_word & ~w_mask) | w_data) >> 0);
            minute <= 6'(((time_word & ~w_mask) | w_data) >> 8);
            hour   <= 5'(((time_word & ~w_mask) | w_data) >> 16);
            cycle  <= 26'h0000000;
        end else if (sec_wrap) begin
            cycle <= 26'h0000000;
            if (second == 6'd59) begin
                second <= 6'h00;
                if (minute == 6'd59) begin
                    minute <= 6'h00;
                    hour   <= (hour == 5'd23) ? 5'h00 : hour + 5'h01;
                end else begin
                    minute <= minute + 6'h01;
                end
            end else begin
                second <= second + 6'h01;
            end
        end else begin
            cycle <= cycle + 26'h0000001;
        end
    end

    // ---------------- event capture ----------------
    for (genvar p = 0; p < 2; p++) begin : g_port
        logic        pend;
        logic [42:0] stamp;

        estp_edge u_edge (
            .clk     (CLOCK),
            .rst     (RST),
            .pin     (EVENT_IN[p]),
            .falling (ctrl[`ESTP_CTRL_EVT_FALL]),
            .hit     (hit[p])
        );

        always_ff @(posedge CLOCK) begin
            if (RST) begin
                pend  <= 1'b0;
                stamp <= 43'h0;
            end else if (hit[p] && ctrl[`ESTP_CTRL_EVT_EN]) begin
                pend  <= 1'b1;
                stamp <= {hour, minute, second, cycle};
            end else if (grant[p]) begin
                pend <= 1'b0;
            end
        end

        assign pend_v[p]  = pend;
        assign stamp_v[p] = stamp;
    end

    // port one wins a tie; port two is written the next cycle
    assign grant    = {pend_v[1] & ~pend_v[0], pend_v[0]};
    assign log_full = log_cnt == (AW + 1)'(LOG_DEPTH);
    assign push     = |pend_v && !log_full;

    assign log_bus.wr_en   = push;
    assign log_bus.wr_addr = wr_ptr;
    assign log_bus.wr_data = grant[1] ? {1'b1, stamp_v[1]} : {1'b0, stamp_v[0]};
    assign log_bus.rd_addr = pop ? rd_ptr + AW'(1) : rd_ptr;

    // log pointers and occupancy; a full log drops the record
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            log_cnt <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            log_cnt <= log_cnt + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end

    // ---------------- second strobe ----------------
    // edge position in 40 ns steps
    assign pps_hit = cycle == 26'(pps_ofs * `ESTP_STEP_CYC);

    // rising pps_ofs steps of 40 ns after the start of the second
    // only while the strobe is enabled
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            SECOND_STROBE_OUT <= 1'b0;
            pulse_cnt         <= 16'h0000;
        end else if (pps_hit && ctrl[`ESTP_CTRL_PPS_EN]) begin
            SECOND_STROBE_OUT <= 1'b1;
            pulse_cnt         <= 16'(PULSE_CYC - 1);
        end else if (pulse_cnt != 16'h0000) begin
            pulse_cnt <= pulse_cnt - 16'h0001;
        end else begin
            SECOND_STROBE_OUT <= 1'b0;
        end
    end

    // ---------------- ascii time tag ----------------
    // two decimal characters of a value below 100
    function automatic logic [15:0] dec2(input logic [6:0] v);
        logic [6:0] tens;
        logic [6:0] units;
        tens  = v / 7'd10;
        units = v % 7'd10;
        return {4'h3, tens[3:0], 4'h3, units[3:0]};
    endfunction

    // line for the coming second, built when sending starts
    always_comb begin
        logic [5:0] ns;
        logic [5:0] nm;
        logic [4:0] nh;
        logic [7:0] fix_ch;
        logic [7:0] sat_ch;
        ns = (second == 6'd59) ? 6'h00 : second + 6'h01;
        nm = (second != 6'd59) ? minute : (minute == 6'd59) ? 6'h00 : minute + 6'h01;
        nh = (second != 6'd59 || minute != 6'd59) ? hour : (hour == 5'd23) ? 5'h00 : hour + 5'h01;
        fix_ch = {5'h06, soln[2:0]};
        // satellite count, 10..12 as : ; <
        sat_ch = (soln[11:8] > 4'd12) ? 8'h3c : {4'h3, soln[11:8]};
        if (soln[11:8] == 4'h0) begin
            fix_ch = 8'h3f;
            sat_ch = 8'h3f;
        end
        // fixed text, date and status layout
        next_line = {"UTC ", dec2(date[22:16]), ".", dec2({3'h0, date[11:8]}), ".",
                     dec2({2'h0, date[4:0]}), " ", dec2({2'h0, nh}), ":", dec2({1'h0, nm}), ":",
                     dec2({1'h0, ns}), " ", fix_ch, sat_ch, 8'h0d, 8'h0a};
    end

    assign tx_take = (TX1_VALID && TX1_READY) || (TX2_VALID && TX2_READY);
    assign tag_done = tx_take && sent == 5'(`ESTP_TAG_LEN - 1);

    // start so the line ends near half a second before the strobe
    // enable and port chosen at start
    // one byte at a time, waits for ready
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            tag_state <= estp_pkg::ESTP_TAG_IDLE;
            tag_port  <= 1'b0;
            line      <= '0;
            sent      <= 5'h00;
            TX_DATA   <= 8'h00;
            TX1_VALID <= 1'b0;
            TX2_VALID <= 1'b0;
        end else begin
            case (tag_state)
                estp_pkg::ESTP_TAG_IDLE: begin
                    if (cycle == 26'(TAG_START_CYC) && ctrl[`ESTP_CTRL_TAG_EN]) begin
                        tag_state <= estp_pkg::ESTP_TAG_SEND;
                        tag_port  <= ctrl[`ESTP_CTRL_TAG_PORT];
                        line      <= next_line << 8;
                        TX_DATA   <= next_line[LINE_W-1 -: 8];
                        sent      <= 5'h00;
                        TX1_VALID <= ~ctrl[`ESTP_CTRL_TAG_PORT];
                        TX2_VALID <= ctrl[`ESTP_CTRL_TAG_PORT];
                    end
                end
                estp_pkg::ESTP_TAG_SEND: begin
                    if (tag_done) begin
                        tag_state <= estp_pkg::ESTP_TAG_IDLE;
                        TX1_VALID <= 1'b0;
                        TX2_VALID <= 1'b0;
                    end else if (tx_take) begin
                        TX_DATA <= line[LINE_W-1 -: 8];
                        line    <= line << 8;
                        sent    <= sent + 5'h01;
                    end
                end
                default: begin
                    tag_state <= estp_pkg::ESTP_TAG_IDLE;
                    TX1_VALID <= 1'b0;
                    TX2_VALID <= 1'b0;
                end
            endcase
        end
    end

    // ---------------- interrupts ----------------
    // sticky status; a new event in the clearing cycle stays set
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            irq_stat <= 4'h0;
        end else begin
            irq_stat <= (irq_stat & ~((do_wr && aw_addr == `ESTP_OFF_IRQ_CLR) ? w_data[3:0] : 4'h0))
                        | {tag_done, pps_hit && ctrl[`ESTP_CTRL_PPS_EN], |pend_v && log_full, push};
        end
    end

    // level output while any enabled status bit is set
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_stat & irq_en);
        end
    end
endmodule

// ===== estp_consts.svh
// constants of the event stamp / second strobe / time tag block
// assumes a single 50 MHz clock and a 32-bit AXI4-Lite register port
`ifndef ESTP_CONSTS_SVH
`define ESTP_CONSTS_SVH

// timing figures in their own units, and cycle counts derived from them
`define ESTP_CLK_PERIOD_NS 20
`define ESTP_SEC_NS        1000000000
`define ESTP_CYC_PER_SEC   (`ESTP_SEC_NS / `ESTP_CLK_PERIOD_NS)
`define ESTP_PULSE_US      8
`define ESTP_PULSE_CYC     ((`ESTP_PULSE_US * 1000) / `ESTP_CLK_PERIOD_NS)
`define ESTP_STEP_NS       40
`define ESTP_STEP_CYC      (`ESTP_STEP_NS / `ESTP_CLK_PERIOD_NS)
`define ESTP_TAG_START_MS  450
`define ESTP_TAG_START_CYC ((`ESTP_TAG_START_MS * 1000000) / `ESTP_CLK_PERIOD_NS)
`define ESTP_LOG_DEPTH     16
`define ESTP_TAG_LEN       26

// register byte offsets
`define ESTP_OFF_CTRL      8'h00
`define ESTP_OFF_PPS_OFS   8'h04
`define ESTP_OFF_TIME      8'h08
`define ESTP_OFF_DATE      8'h0c
`define ESTP_OFF_SOLN      8'h10
`define ESTP_OFF_LOG_CNT   8'h14
`define ESTP_OFF_LOG_HI    8'h18
`define ESTP_OFF_LOG_LO    8'h1c
`define ESTP_OFF_IRQ_STAT  8'h20
`define ESTP_OFF_IRQ_CLR   8'h24
`define ESTP_OFF_IRQ_EN    8'h28

// control bits
`define ESTP_CTRL_EVT_EN   0
`define ESTP_CTRL_EVT_FALL 1
`define ESTP_CTRL_PPS_EN   2
`define ESTP_CTRL_TAG_EN   3
`define ESTP_CTRL_TAG_PORT 4

// interrupt status bits
`define ESTP_IRQ_EVENT     0
`define ESTP_IRQ_OVERFLOW  1
`define ESTP_IRQ_SECOND    2
`define ESTP_IRQ_TAG_DONE  3

// reset values and bus response codes
`define ESTP_CTRL_RST      5'h00
`define ESTP_PPS_OFS_RST   24'h000000
`define ESTP_DATE_RST      32'h00000101
`define ESTP_SOLN_RST      12'h000
`define ESTP_RESP_OKAY     2'h0
`define ESTP_RESP_SLVERR   2'h2

`endif

// ===== estp_pkg.sv
// types shared by the event stamp / second strobe / time tag block
// assumes nothing beyond the constants header
package estp_pkg;
    typedef enum logic {
        ESTP_TAG_IDLE,
        ESTP_TAG_SEND
    } estp_tag_state_t;

    // one logged event: port (0 = port 1) and hh:mm:ss plus cycle of second
    typedef struct packed {
        logic        port;
        logic [4:0]  hour;
        logic [5:0]  minute;
        logic [5:0]  second;
        logic [25:0] cycle;
    } estp_record_t;
endpackage

// ===== estp_log_if.sv
// carrier between the block and its event log memory
// assumes one writer and one reader on the same clock
`timescale 1ns/100ps
interface estp_log_if #(
    parameter int unsigned AW = 4
);
    logic                  wr_en;
    logic [AW-1:0]         wr_addr;
    estp_pkg::estp_record_t wr_data;
    logic [AW-1:0]         rd_addr;
    estp_pkg::estp_record_t rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ===== estp_log_mem.sv
// event log memory: one write port, registered read data
// assumes the controller keeps pointers and never writes when full
`timescale 1ns/100ps
module estp_log_mem #(
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk,
    estp_log_if.mem  log
);
    estp_pkg::estp_record_t store [DEPTH];

    // write port
    always_ff @(posedge clk) begin
        if (log.wr_en) begin
            store[log.wr_addr] <= log.wr_data;
        end
    end

    // read data always from a register, one cycle after the address
    always_ff @(posedge clk) begin
        log.rd_data <= store[log.rd_addr];
    end
endmodule

// ===== estp_edge.sv
// trigger input synchroniser and edge detector
// assumes the pin is asynchronous to clk; hit is a one-cycle pulse
`timescale 1ns/100ps
module estp_edge (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    input  wire logic falling,
    output logic      hit
);
    logic sync_a;
    logic sync_b;
    logic last;

    // two-stage synchroniser, then one stage of history
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            last   <= 1'b0;
        end else begin
            sync_a <= pin;
            sync_b <= sync_a;
            last   <= sync_b;
        end
    end

    // one pulse per chosen transition
    always_ff @(posedge clk) begin
        if (rst) begin
            hit <= 1'b0;
        end else begin
            hit <= falling ? (last & ~sync_b) : (~last & sync_b);
        end
    end
endmodule

// ===== estp_props.sv
// checker for the timing block: bus answers, strobe width, tag byte stream
// assumes it is bound onto estp_top and sees its top-level ports only
`timescale 1ns/100ps
module estp_props (
    input wire logic       CLOCK, RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY,
    input wire logic       ARVALID, ARREADY, RVALID, RREADY, SECOND_STROBE_OUT,
    input wire logic       TX1_VALID, TX1_READY, TX2_VALID, TX2_READY,
    input wire logic [7:0] TX_DATA
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    int hi_cnt;
    // length of the strobe pulse seen so far
    always_ff @(posedge CLOCK) begin
        if (RST)
            hi_cnt <= 0;
        else
            hi_cnt <= SECOND_STROBE_OUT ? hi_cnt + 1 : 0;
    end
    a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
        else $error("write not answered");
    a_bresp_hold: assert property (BVALID && !BREADY |=> BVALID) else $error("write answer dropped");
    a_read_answer: assert property (ARVALID && ARREADY |=> RVALID) else $error("read not answered");
    a_strobe_width: assert property ($fell(SECOND_STROBE_OUT) |-> hi_cnt == 400)
        else $error("strobe width wrong");
    a_strobe_min: assert property ($rose(SECOND_STROBE_OUT) |=> SECOND_STROBE_OUT [*8])
        else $error("strobe too short");
    a_tx1_hold: assert property (TX1_VALID && !TX1_READY |=> TX1_VALID && $stable(TX_DATA))
        else $error("port one byte not held");
    a_tx2_hold: assert property (TX2_VALID && !TX2_READY |=> TX2_VALID && $stable(TX_DATA))
        else $error("port two byte not held");
    a_tx_one_port: assert property (!(TX1_VALID && TX2_VALID)) else $error("both ports offered");
    a_line_end: assert property (TX1_VALID && TX1_READY && TX_DATA == 8'h0a |=> !TX1_VALID)
        else $error("bytes after line feed");
    cover property ($rose(SECOND_STROBE_OUT));
    cover property (TX1_VALID && TX1_READY);
    cover property (TX2_VALID && TX2_READY);
endmodule

// ===== estp_term.sv
// serial listener on both tag ports: takes bytes on a ready handshake
// assumes one clock; slow mode accepts one byte every fourth cycle
`timescale 1ns/100ps
module estp_term (
    input wire logic       clk, rst, slow, tx1_valid, tx2_valid,
    input wire logic [7:0] tx_data,
    output logic           tx1_ready, tx2_ready
);
    logic [7:0] rx_q [0:63];
    int         n, cnt1, cnt2;
    logic [1:0] ph;
    // ready handshake, bytes kept in arrival order
    always_ff @(posedge clk) begin
        if (rst) begin
            ph <= 2'h0; n <= 0; cnt1 <= 0; cnt2 <= 0; tx1_ready <= 1'b0; tx2_ready <= 1'b0;
        end else begin
            ph <= ph + 2'h1;
            tx1_ready <= !slow || ph == 2'h2;
            tx2_ready <= !slow || ph == 2'h2;
            if ((tx1_valid && tx1_ready) || (tx2_valid && tx2_ready)) begin
                rx_q[n[5:0]] <= tx_data;
                n <= n + 1;
            end
            if (tx1_valid && tx1_ready) cnt1 <= cnt1 + 1;
            if (tx2_valid && tx2_ready) cnt2 <= cnt2 + 1;
        end
    end
endmodule

// ===== test_event_stamp_and_pps_timetag.sv
// self-checking bench: registers, event log, interrupt, strobe, tag lines
// assumes short second counts so a second takes 2000 cycles
`timescale 1ns/100ps
module test_event_stamp_and_pps_timetag;
    logic clk = 0, rst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, slow = 0;
    logic [7:0] awaddr = 0, araddr = 0, txd;
    logic [31:0] wdata = 0, rdata;
    logic [1:0] evt = 0, bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, strobe, tx1v, tx2v, tx1r, tx2r, irq;
    int bad_count = 0, compares = 0, cyc = 0, t0, t1, base, w;
    always #10 clk = ~clk;
    estp_top #(.CYC_PER_SEC(2000), .TAG_START_CYC(900)) dut (.CLOCK(clk), .RST(rst), .AWADDR(awaddr),
        .AWVALID(awv), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wv), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arv), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .EVENT_IN(evt),
        .SECOND_STROBE_OUT(strobe), .TX_DATA(txd), .TX1_VALID(tx1v), .TX1_READY(tx1r),
        .TX2_VALID(tx2v), .TX2_READY(tx2r), .IRQ(irq));
    estp_term term (.clk(clk), .rst(rst), .slow(slow), .tx1_valid(tx1v), .tx2_valid(tx2v),
        .tx_data(txd), .tx1_ready(tx1r), .tx2_ready(tx2r));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic done = 0;
        @(posedge clk);
        awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
        while (!done) begin
            @(posedge clk);
            if (awv && awready) awv <= 0;
            if (wv && wready) wv <= 0;
            if (bvalid === 1'b1) begin bready <= 0; done = 1; chk(32'(bresp), 32'(er)); end
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
        logic done = 0;
        @(posedge clk);
        araddr <= a; arv <= 1; rready <= 1;
        while (!done) begin
            @(posedge clk);
            if (arv && arready) arv <= 0;
            if (rvalid === 1'b1) begin rready <= 0; done = 1; chk(rdata & m, e); chk(32'(rresp), 32'(er)); end
        end
    endtask
    task automatic rise(output int t);
        do @(posedge clk); while (strobe !== 1'b1);
        t = cyc;
    endtask
    task automatic line_chk(input int b, input string s);
        for (int i = 0; i < s.len(); i++) chk(32'(term.rx_q[6'(b + i)]), 32'(s[i]));
    endtask
    // reset values, unmapped and read-only places
    task automatic t_regs;
        rd(8'h00, 32'h0, 32'hffffffff, 2'h0);
        rd(8'h0c, 32'h101, 32'hffffffff, 2'h0);
        rd(8'h3c, 32'h0, 32'hffffffff, 2'h2);
        wr(8'h14, 32'h1, 2'h2);
    endtask
    // capture gating, both ports, edge polarity, interrupt raise and clear
    task automatic t_events;
        wr(8'h28, 32'h1, 2'h0);
        evt <= 2'b01;
        repeat (10) @(posedge clk);
        rd(8'h14, 32'h0, 32'hffffffff, 2'h0);
        evt <= 2'b00;
        wr(8'h00, 32'h1, 2'h0);
        evt <= 2'b10;
        repeat (10) @(posedge clk);
        rd(8'h14, 32'h1, 32'hffffffff, 2'h0);
        chk(32'(irq), 32'h1);
        rd(8'h18, 32'h80000000, 32'hffffffff, 2'h0);
        rd(8'h1c, 32'h0, 32'h0, 2'h0);
        wr(8'h24, 32'h1, 2'h0);
        repeat (3) @(posedge clk);
        chk(32'(irq), 32'h0);
        evt <= 2'b00;
        wr(8'h00, 32'h3, 2'h0);
        evt <= 2'b01;
        repeat (10) @(posedge clk);
        rd(8'h14, 32'h0, 32'hffffffff, 2'h0);
        evt <= 2'b00;
        repeat (10) @(posedge clk);
        rd(8'h18, 32'h0, 32'h80000000, 2'h0);
        rd(8'h1c, 32'h0, 32'h0, 2'h0);
    endtask
    // strobe timing and offset, tag lines on both ports, strobe disabled
    task automatic t_tag;
        wr(8'h10, 32'h0a02, 2'h0);
        wr(8'h08, 32'h0, 2'h0);
        wr(8'h00, 32'hc, 2'h0);
        base = term.n;
        rise(t0);
        chk(32'(term.cnt1), 32'd26);
        line_chk(base, "UTC 00.01.01 00:00:01 2:\r\n");
        for (w = 0; strobe === 1'b1; w++) @(posedge clk);
        chk(32'(w), 32'd400);
        wr(8'h04, 32'h5, 2'h0);
        rise(t1);
        chk(32'(t1 - t0), 32'd2010);
        slow <= 1;
        wr(8'h10, 32'h0, 2'h0);
        wr(8'h00, 32'h18, 2'h0);
        base = term.n;
        while (term.cnt2 < 26) @(posedge clk);
        line_chk(base + 22, "??\r\n");
        w = 0;
        repeat (2100) begin @(posedge clk); if (strobe === 1'b1) w++; end
        chk(32'(w), 32'h0);
    endtask
    task automatic print_verdict;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // cycle count and hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin bad_count++; print_verdict; end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        t_regs;
        t_events;
        t_tag;
        print_verdict;
    end
endmodule
bind estp_top estp_props u_props (.CLOCK(CLOCK), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .SECOND_STROBE_OUT(SECOND_STROBE_OUT),
    .TX1_VALID(TX1_VALID), .TX1_READY(TX1_READY), .TX2_VALID(TX2_VALID), .TX2_READY(TX2_READY),
    .TX_DATA(TX_DATA));
